/* File: rtl/srx_rx_core.sv */
`timescale 1ns/100ps
`default_nettype none
// ==================================================
module srx_rx_core (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxd,
	input wire logic serial_sample_clock,
	input wire logic sclk_in,
	output logic sclk_out,
	output logic sclk_oe_n,
	input wire logic tx_shift_take,
	input wire logic tx_shift_idle,
	output logic receive_interrupt
);
	// ==================================================
	// Pin synchronisers
	logic rxd_m, rxd_s, ssc_m, ssc_s, ssc_p, sck_m, sck_s, sck_p;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{rxd_m, rxd_s} <= 2'h3;
			{ssc_m, ssc_s, ssc_p} <= 3'h0;
			{sck_m, sck_s, sck_p} <= 3'h7;
		end else begin
			rxd_m <= rxd;
			rxd_s <= rxd_m;
			ssc_m <= serial_sample_clock;
			ssc_s <= ssc_m;
			ssc_p <= ssc_s;
			sck_m <= sclk_in;
			sck_s <= sck_m;
			sck_p <= sck_s;
		end
	end

	// ==================================================
	// State
	srx_pkg::srx_mode_type mode_q, mode_d;
	srx_pkg::srx_err_type err_q, err_d, err_set;
	logic ioc_q, ioc_d, sclks_q, sclks_d, rb8_q, rb8_d, wbuf_q, wbuf_d, stop_length_select_q, stop_length_select_d;
	logic tx_buffer_empty_flag_q, tx_buffer_empty_flag_d, buf_full_q, buf_full_d, sh_full_q, sh_full_d, src_fifo_q, src_fifo_d;
	logic clk_q, clk_d, idle_p_q, rint_q, rint_d;
	logic [1:0] dpx_q, dpx_d, ril_q, ril_d;
	logic [2:0] fcnf_q, fcnf_d;
	logic [7:0] buf_q, buf_d;
	logic [8:0] sh_q, sh_d, acc_q, acc_d;
	logic [3:0] idx_q, idx_d;
	logic [31:0] prdata_q, prdata_d;

	// ==================================================
	// Helpers
	logic tick, setup, acc, wr, rd, hold, dbl, fifo_en, internal, keep_sh, stop_clk, run;
	logic ext_edge, sync_stb, u_stb, u_val, frame_done, frame_end, stop_stb, calc_par;
	logic move_bf, move_sb, push, pop, fifo_clr, fifo_full, fifo_empty, inh_full;
	logic [2:0] limit, thr, fifo_cnt;
	logic [7:0] fifo_dout;

	function automatic logic mapped(input logic [7:0] a);
		mapped = a == srx_pkg::ADR_CTRL || a == srx_pkg::ADR_BUF || a == srx_pkg::ADR_MODE0 ||
			a == srx_pkg::ADR_MODE1 || a == srx_pkg::ADR_MODE2 || a == srx_pkg::ADR_FCNF ||
			a == srx_pkg::ADR_RFC;
	endfunction

	// Usable receive depth per duplex code; TX-only and unset codes give none
	function automatic logic [2:0] rx_limit(input logic [1:0] d);
		case (d)
			srx_pkg::DPX_RX: rx_limit = srx_pkg::FIFO_DEPTH;
			srx_pkg::DPX_FULL: rx_limit = srx_pkg::FIFO_HALF;
			default: rx_limit = 3'h0;
		endcase
	endfunction

	assign tick = ssc_s && !ssc_p;
	assign setup = psel && !penable;
	assign acc = psel && penable;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	// Internal moves pause while a data read is pending so the captured byte stays the one popped
	assign hold = psel && !pwrite && paddr == srx_pkg::ADR_BUF;
	assign internal = mode_q.sync && !ioc_q;
	assign dbl = wbuf_q || !internal;
	assign fifo_en = wbuf_q && fcnf_q[srx_pkg::FC_FIFO_USE_ENABLE] && dpx_q[0];
	assign limit = fifo_en ? rx_limit(dpx_q) : 3'h0;
	assign thr = (ril_q == srx_pkg::RIL_FOUR) ? srx_pkg::FIFO_DEPTH : {1'b0, ril_q};
	assign keep_sh = internal || (fifo_en && fcnf_q[srx_pkg::FC_INH]);
	assign stop_clk = sh_full_q || (!dbl && buf_full_q) || err_q.oerr;
	assign run = mode_q.receive_enable && internal && !stop_clk;
	assign ext_edge = mode_q.sync && ioc_q && (sclks_q ? (sck_p && !sck_s) : (sck_s && !sck_p));
	assign sync_stb = mode_q.receive_enable && ((internal && run && tick && !clk_q) || ext_edge);
	assign stop_stb = u_stb && idx_q == (mode_q.nine || mode_q.pen ?
		srx_pkg::UART_STOP_X : srx_pkg::UART_STOP);
	assign frame_end = stop_stb;
	assign calc_par = ^acc_q[7:0] ^ mode_q.podd;
	assign inh_full = fifo_en && fcnf_q[srx_pkg::FC_INH] && sh_full_q && buf_full_q && fifo_full;

	srx_bit_sampler u_samp (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick),
		.rxd(rxd_s),
		.en(mode_q.receive_enable && !mode_q.sync),
		.frame_end(frame_end),
		.bit_stb(u_stb),
		.bit_val(u_val)
	);

	srx_rx_fifo u_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.clr(fifo_clr),
		.push(push),
		.din(buf_q),
		.pop(pop),
		.limit(limit),
		.dout(fifo_dout),
		.count(fifo_cnt),
		.full(fifo_full),
		.empty(fifo_empty)
	);

	// ==================================================
	// Next-state logic
	always_comb begin
		mode_d = mode_q;
		ioc_d = ioc_q;
		sclks_d = sclks_q;
		rb8_d = rb8_q;
		wbuf_d = wbuf_q;
		stop_length_select_d = stop_length_select_q;
		dpx_d = dpx_q;
		ril_d = ril_q;
		fcnf_d = fcnf_q;
		buf_d = buf_q;
		buf_full_d = buf_full_q;
		sh_d = sh_q;
		sh_full_d = sh_full_q;
		acc_d = acc_q;
		idx_d = idx_q;
		clk_d = clk_q;
		rint_d = 1'b0;
		frame_done = 1'b0;
		err_set = '0;
		push = 1'b0;
		pop = 1'b0;
		fifo_clr = 1'b0;
		prdata_d = prdata_q;
		src_fifo_d = src_fifo_q;
		// Internal shift clock: one toggle per sample tick, parked high when stopped
		if (!run) clk_d = 1'b1;
		else if (tick) clk_d = !clk_q;
		// Bit assembly
		if (!mode_q.receive_enable) begin
			idx_d = '0;
		end else if (mode_q.sync) begin
			if (sync_stb) begin
				acc_d = {1'b0, rxd_s, acc_q[7:1]};
				idx_d = idx_q + 4'h1;
				if (idx_q == srx_pkg::SYNC_LAST) begin
					idx_d = '0;
					frame_done = 1'b1;
				end
			end
		end else if (u_stb) begin
			idx_d = idx_q + 4'h1;
			if (stop_stb) begin
				idx_d = '0;
				frame_done = 1'b1;
				err_set.ferr = !u_val;
				err_set.perr = mode_q.pen && !mode_q.nine && (calc_par != acc_q[8]);
			end else if (idx_q != 4'h0 && idx_q <= srx_pkg::UART_DATA_LAST) begin
				acc_d = {acc_q[8], u_val, acc_q[7:1]};
			end else if (idx_q != 4'h0) begin
				acc_d = {u_val, acc_q[7:0]};
			end
		end
		// Underrun on an empty transmit side, only with transmit double buffering
		if (mode_q.sync && wbuf_q && tx_buffer_empty_flag_q && tx_shift_idle &&
			(ext_edge || (internal && !idle_p_q))) err_set.perr = 1'b1;
		// Storage moves: buffer to FIFO, then shift stage to buffer
		move_bf = !hold && fifo_en && buf_full_q && !fifo_full;
		if (move_bf) begin
			push = 1'b1;
			buf_full_d = 1'b0;
		end
		move_sb = !hold && sh_full_q && (!buf_full_q || move_bf);
		if (move_sb) begin
			buf_d = sh_q[7:0];
			rb8_d = sh_q[8];
			buf_full_d = 1'b1;
			sh_full_d = 1'b0;
		end
		if (frame_done) begin
			rint_d = !fifo_en;
			if (!keep_sh && buf_full_q && !move_bf) begin
				err_set.oerr = 1'b1;
			end else begin
				sh_d = acc_d;
				sh_full_d = 1'b1;
			end
		end
		if (push && fifo_cnt + 3'h1 == thr) rint_d = 1'b1;
		// Register reads: capture in setup, side effects at the access edge
		if (setup) begin
			src_fifo_d = fifo_en && !fifo_empty;
			case (paddr)
				srx_pkg::ADR_CTRL: prdata_d = {24'h0, rb8_q, 2'h0, err_q, ioc_q, sclks_q};
				srx_pkg::ADR_BUF: prdata_d = {24'h0, (fifo_en && !fifo_empty) ? fifo_dout : buf_q};
				srx_pkg::ADR_MODE0: prdata_d = {27'h0, mode_q};
				srx_pkg::ADR_MODE1: prdata_d = {25'h0, dpx_q, 5'h0};
				srx_pkg::ADR_MODE2: prdata_d = {24'h0, buf_full_q, tx_buffer_empty_flag_q, wbuf_q, stop_length_select_q, 4'h0};
				srx_pkg::ADR_FCNF: prdata_d = {29'h0, fcnf_q};
				srx_pkg::ADR_RFC: prdata_d = {27'h0, fifo_cnt, ril_q};
				default: prdata_d = 32'h0;
			endcase
		end
		if (rd && paddr == srx_pkg::ADR_BUF) begin
			if (src_fifo_q) pop = 1'b1;
			else if (!move_sb) buf_full_d = 1'b0;
		end
		// Register writes
		if (wr) begin
			case (paddr)
				srx_pkg::ADR_CTRL: begin
					ioc_d = pwdata[srx_pkg::CTRL_IOC];
					sclks_d = pwdata[srx_pkg::CTRL_SCLKS];
				end
				srx_pkg::ADR_MODE0: mode_d = srx_pkg::srx_mode_type'(pwdata[4:0]);
				srx_pkg::ADR_MODE1: dpx_d = pwdata[srx_pkg::M1_DPX_LO +: 2];
				srx_pkg::ADR_MODE2: begin
					wbuf_d = pwdata[srx_pkg::M2_WBUF];
					stop_length_select_d = pwdata[srx_pkg::M2_STOP_LENGTH_SELECT];
				end
				srx_pkg::ADR_FCNF: fcnf_d = pwdata[2:0];
				srx_pkg::ADR_RFC: begin
					ril_d = pwdata[1:0];
					fifo_clr = pwdata[srx_pkg::RFC_CLR_LO +: 2] == srx_pkg::RFC_CLR;
				end
				default: ;
			endcase
		end
		// Hardware stops reception once every stage is full, with the FIFO on and FC_INH set, or FC_CNT set under the internal clock
		if (inh_full) mode_d.receive_enable = 1'b0;
		if (internal && fifo_en && fcnf_q[srx_pkg::FC_CNT] && sh_full_q && buf_full_q &&
			fifo_full) mode_d.receive_enable = 1'b0;
		// Clear only the flags that were shown; a new event in this cycle survives
		err_d = err_q;
		if (rd && paddr == srx_pkg::ADR_CTRL)
			err_d = err_q & ~srx_pkg::srx_err_type'(prdata_q[srx_pkg::CTRL_ERR_LO +: 3]);
		err_d = err_d | err_set;
		if (mode_q.sync) err_d.ferr = 1'b0;
		tx_buffer_empty_flag_d = tx_buffer_empty_flag_q;
		if (wr && paddr == srx_pkg::ADR_BUF) tx_buffer_empty_flag_d = 1'b0;
		if (tx_shift_take) tx_buffer_empty_flag_d = 1'b1;
	end

	// ==================================================
	// Registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= '0;
			err_q <= '0;
			ioc_q <= 1'b0;
			sclks_q <= 1'b0;
			rb8_q <= 1'b0;
			wbuf_q <= 1'b0;
			stop_length_select_q <= 1'b0;
			tx_buffer_empty_flag_q <= srx_pkg::TX_BUFFER_EMPTY_FLAG_RST;
			buf_full_q <= 1'b0;
			sh_full_q <= 1'b0;
			src_fifo_q <= 1'b0;
			clk_q <= 1'b1;
			idle_p_q <= 1'b1;
			rint_q <= 1'b0;
			dpx_q <= '0;
			ril_q <= '0;
			fcnf_q <= '0;
			buf_q <= '0;
			sh_q <= '0;
			acc_q <= '0;
			idx_q <= '0;
			prdata_q <= '0;
		end else begin
			mode_q <= mode_d;
			err_q <= err_d;
			ioc_q <= ioc_d;
			sclks_q <= sclks_d;
			rb8_q <= rb8_d;
			wbuf_q <= wbuf_d;
			stop_length_select_q <= stop_length_select_d;
			tx_buffer_empty_flag_q <= tx_buffer_empty_flag_d;
			buf_full_q <= buf_full_d;
			sh_full_q <= sh_full_d;
			src_fifo_q <= src_fifo_d;
			clk_q <= clk_d;
			idle_p_q <= tx_shift_idle;
			rint_q <= rint_d;
			dpx_q <= dpx_d;
			ril_q <= ril_d;
			fcnf_q <= fcnf_d;
			buf_q <= buf_d;
			sh_q <= sh_d;
			acc_q <= acc_d;
			idx_q <= idx_d;
			prdata_q <= prdata_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = acc && !mapped(paddr);
	assign sclk_out = clk_q;
	assign sclk_oe_n = !internal;
	assign receive_interrupt = rint_q;

	// ==================================================
	// Checks
	sequence s_stage_full;
		sh_full_q && !hold;
	endsequence
	property p_buf_fill;
		@(posedge pclk) disable iff (!presetn)
		s_stage_full ##0 !buf_full_q |=> buf_full_q;
	endproperty
	a_buf_fill: assert property (p_buf_fill) else $error("buffer did not take frame");
	property p_err_clear;
		@(posedge pclk) disable iff (!presetn)
		(rd && paddr == srx_pkg::ADR_CTRL && !frame_done && !ext_edge && !internal &&
			prdata_q[4:2] == err_q) |=> err_q == 3'h0;
	endproperty
	a_err_clear: assert property (p_err_clear) else $error("errors not cleared on read");
	property p_oerr_stops;
		@(posedge pclk) disable iff (!presetn)
		(internal && err_q.oerr) |=> sclk_out && !sync_stb;
	endproperty
	a_oerr_stops: assert property (p_oerr_stops) else $error("clock runs with overrun");
	property p_ferr_cause;
		@(posedge pclk) disable iff (!presetn)
		$rose(err_q.ferr) |-> $past(stop_stb && !u_val);
	endproperty
	a_ferr_cause: assert property (p_ferr_cause) else $error("framing error without cause");
	property p_tx_buffer_empty_flag;
		@(posedge pclk) disable iff (!presetn)
		tx_shift_take |=> tx_buffer_empty_flag_q;
	endproperty
	a_tx_buffer_empty_flag: assert property (p_tx_buffer_empty_flag) else $error("tx empty flag missed");
	property p_inhibit;
		@(posedge pclk) disable iff (!presetn)
		inh_full |=> !mode_q.receive_enable;
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("receive not inhibited");
	property p_no_fifo;
		@(posedge pclk) disable iff (!presetn)
		!wbuf_q |=> $stable(fifo_cnt) || fifo_cnt < $past(fifo_cnt);
	endproperty
	a_no_fifo: assert property (p_no_fifo) else $error("fifo filled without double buffer");
	property p_single_stop;
		@(posedge pclk) disable iff (!presetn)
		(internal && !wbuf_q && buf_full_q && !acc) |=> sclk_out [*2];
	endproperty
	a_single_stop: assert property (p_single_stop) else $error("clock runs with full buffer");
endmodule
`default_nettype wire

/* File: rtl/srx_pkg.sv */
package srx_pkg;
	// ==================================================
	// Register map (byte addresses on APB)
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_BUF = 8'h04;
	localparam logic [7:0] ADR_MODE0 = 8'h08;
	localparam logic [7:0] ADR_MODE1 = 8'h0C;
	localparam logic [7:0] ADR_MODE2 = 8'h10;
	localparam logic [7:0] ADR_FCNF = 8'h14;
	localparam logic [7:0] ADR_RFC = 8'h18;
	// ==================================================
	// Field positions
	localparam int CTRL_RB8 = 7;
	localparam int CTRL_ERR_LO = 2;
	localparam int CTRL_IOC = 1;
	localparam int CTRL_SCLKS = 0;
	localparam int M1_DPX_LO = 5;
	localparam int M2_RX_BUFFER_FULL_FLAG = 7;
	localparam int M2_TX_BUFFER_EMPTY_FLAG = 6;
	localparam int M2_WBUF = 5;
	localparam int M2_STOP_LENGTH_SELECT = 4;
	localparam int FC_FIFO_USE_ENABLE = 0;
	localparam int FC_CNT = 1;
	localparam int FC_INH = 2;
	localparam int RFC_CLR_LO = 6;
	localparam int RFC_CNT_LO = 2;
	// ==================================================
	// Codes and counts
	localparam logic [1:0] DPX_RX = 2'h1;
	localparam logic [1:0] DPX_FULL = 2'h3;
	localparam logic [1:0] RIL_FOUR = 2'h0;
	localparam logic [1:0] RFC_CLR = 2'h3;
	localparam logic [2:0] FIFO_DEPTH = 3'h4;
	localparam logic [2:0] FIFO_HALF = 3'h2;
	localparam logic [3:0] TICK_S1 = 4'h6;
	localparam logic [3:0] TICK_S2 = 4'h7;
	localparam logic [3:0] TICK_S3 = 4'h8;
	localparam logic [3:0] SYNC_LAST = 4'h7;
	localparam logic [3:0] UART_DATA_LAST = 4'h8;
	localparam logic [3:0] UART_STOP = 4'h9;
	localparam logic [3:0] UART_STOP_X = 4'hA;
	localparam logic TX_BUFFER_EMPTY_FLAG_RST = 1'b1;
	// ==================================================
	// Carriers
	typedef struct packed {logic podd; logic pen; logic nine; logic receive_enable; logic sync;} srx_mode_type;
	typedef struct packed {logic oerr; logic perr; logic ferr;} srx_err_type;
endpackage

/* File: rtl/srx_bit_sampler.sv */
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// Start detect, 16-tick bit timing, 3-sample majority
module srx_bit_sampler (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick,
	input wire logic rxd,
	input wire logic en,
	input wire logic frame_end,
	output logic bit_stb,
	output logic bit_val
);
	logic busy_q, busy_d, first_q, first_d, s1_q, s1_d, s2_q, s2_d, stb_q, stb_d, val_q, val_d;
	logic [3:0] cnt_q, cnt_d;
	logic maj;

	always_comb begin
		busy_d = busy_q;
		first_d = first_q;
		cnt_d = cnt_q;
		s1_d = s1_q;
		s2_d = s2_q;
		stb_d = 1'b0;
		val_d = val_q;
		maj = (s1_q & s2_q) | (s1_q & rxd) | (s2_q & rxd);
		if (!en || frame_end) begin
			busy_d = 1'b0;
		end else if (tick && !busy_q && !rxd) begin
			busy_d = 1'b1;
			first_d = 1'b1;
			cnt_d = '0;
		end else if (tick && busy_q) begin
			cnt_d = cnt_q + 4'h1;
			if (cnt_d == srx_pkg::TICK_S1) s1_d = rxd;
			if (cnt_d == srx_pkg::TICK_S2) s2_d = rxd;
			if (cnt_d == srx_pkg::TICK_S3) begin
				val_d = maj;
				first_d = 1'b0;
				// A start bit voted high was a glitch: drop back to hunting
				if (first_q && maj) busy_d = 1'b0;
				else stb_d = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q <= 1'b0;
			first_q <= 1'b0;
			cnt_q <= '0;
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			stb_q <= 1'b0;
			val_q <= 1'b1;
		end else begin
			busy_q <= busy_d;
			first_q <= first_d;
			cnt_q <= cnt_d;
			s1_q <= s1_d;
			s2_q <= s2_d;
			stb_q <= stb_d;
			val_q <= val_d;
		end
	end

	assign bit_stb = stb_q;
	assign bit_val = val_q;

	property p_majority;
		@(posedge pclk) disable iff (!presetn)
		(en && !frame_end && tick && busy_q && !first_q && cnt_q == srx_pkg::TICK_S2 &&
			s1_q == s2_q)
		|=> bit_stb && bit_val == $past(s1_q);
	endproperty
	a_majority: assert property (p_majority) else $error("majority vote wrong");
endmodule
`default_nettype wire

/* File: rtl/srx_rx_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// Four-byte receive FIFO with a movable usable depth
module srx_rx_fifo (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clr,
	input wire logic push,
	input wire logic [7:0] din,
	input wire logic pop,
	input wire logic [2:0] limit,
	output logic [7:0] dout,
	output logic [2:0] count,
	output logic full,
	output logic empty
);
	logic [7:0] mem [0:3];
	logic [1:0] wp_q, wp_d, rp_q, rp_d;
	logic [2:0] cnt_q, cnt_d;
	logic do_push, do_pop;

	always_comb begin
		full = cnt_q >= limit;
		empty = cnt_q == 3'h0;
		do_push = push && !full;
		do_pop = pop && !empty;
		wp_d = wp_q + {1'b0, do_push};
		rp_d = rp_q + {1'b0, do_pop};
		cnt_d = cnt_q + {2'h0, do_push} - {2'h0, do_pop};
		if (clr) begin
			wp_d = '0;
			rp_d = '0;
			cnt_d = '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge pclk) begin
		if (do_push) mem[wp_q] <= din;
	end

	assign dout = mem[rp_q];
	assign count = cnt_q;

	property p_no_overfill;
		@(posedge pclk) disable iff (!presetn)
		(full && !pop && !clr) |=> count == $past(count);
	endproperty
	a_no_overfill: assert property (p_no_overfill) else $error("fifo grew past limit");
endmodule
`default_nettype wire

/* File: testbench/srx_remote_uart.sv */
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// Remote transmitter: sends one frame, LSB first, 16 ticks a bit, or one bit per falling clock edge when sync
module srx_remote_uart (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ssc,
	input wire logic sync,
	input wire logic sclk,
	input wire logic go,
	input wire logic [10:0] frame,
	input wire logic [3:0] len,
	output logic rxd,
	output logic busy
);
	logic ssc_q, sclk_q;
	logic [3:0] tk;
	logic [3:0] nb;
	logic [10:0] sh;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ssc_q <= 1'b0;
			sclk_q <= 1'b1;
			tk <= 4'h0;
			nb <= 4'h0;
			sh <= 11'h7FF;
			rxd <= 1'b1;
			busy <= 1'b0;
		end else begin
			ssc_q <= ssc;
			sclk_q <= sclk;
			if (go && !busy) begin
				sh <= frame;
				nb <= len;
				tk <= 4'h0;
				busy <= 1'b1;
				// A clocked frame puts its first bit out on the first falling edge
				if (!sync) rxd <= frame[0];
			end else if (busy && sync && sclk != sclk_q) begin
				if (!sclk) begin
					rxd <= sh[0];
					sh <= sh >> 1;
					nb <= nb - 4'h1;
				end else if (nb == 4'h0) begin
					// Let go only after the receiver's last rising edge
					busy <= 1'b0;
					rxd <= 1'b1;
				end
			end else if (busy && !sync && ssc && !ssc_q) begin
				tk <= tk + 4'h1;
				if (tk == 4'hF) begin
					if (nb == 4'h1) begin
						// Line returns to its idle high level between frames
						busy <= 1'b0;
						rxd <= 1'b1;
					end else begin
						nb <= nb - 4'h1;
						sh <= sh >> 1;
						rxd <= sh[1];
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: testbench/tb_srx_rx_core.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_srx_rx_core;
	typedef struct {logic [31:0] d; logic [31:0] m; logic e;} srx_exp_type;
	logic pclk, presetn, psel, penable, pwrite, ssc, go, rxd, busy, take, sy, sck, idle;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic pready, pslverr, sclk_out, sclk_oe_n, irq;
	logic [10:0] frame;
	logic [3:0] len;
	logic [1:0] div;
	logic [7:0] b[4];
	logic p;
	int fail_count = 0;
	int samples_checked = 0;
	int irq_n = 0;
	int seed = 25614;
	srx_exp_type q[$];
	srx_exp_type x;
	srx_rx_core u_srx_rx_core (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
		.serial_sample_clock(ssc), .sclk_in(sck), .sclk_out(sclk_out),
		.sclk_oe_n(sclk_oe_n), .tx_shift_take(take), .tx_shift_idle(idle),
		.receive_interrupt(irq));
	srx_remote_uart u_srx_remote_uart (.pclk(pclk), .presetn(presetn), .ssc(ssc),
		.sync(sy), .sclk(sclk_oe_n ? sck : sclk_out),
		.go(go), .frame(frame), .len(len), .rxd(rxd), .busy(busy));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// Sample clock: one tick every four system cycles
	always @(posedge pclk) begin
		div <= div + 2'h1;
		ssc <= div[1];
	end
	always @(posedge pclk) begin
		if (!presetn) begin
			irq_n <= 0;
		end else if (irq === 1'b1) begin
			irq_n <= irq_n + 1;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Monitor: every completed read takes the oldest expectation
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			x = q.pop_front();
			chk(prdata & x.m, x.d);
			chk({31'h0, pslverr}, {31'h0, x.e});
		end
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m = 32'hFFFFFFFF, input logic e = 1'b0);
		int n;
		if (!w) q.push_back('{d & m, m, e});
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			fail_count++;
			$display("MISMATCH at %0t: bus timeout", $time);
			complete_run();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic do_reset();
		presetn <= 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask
	task automatic send(input logic [7:0] d, input logic pen, input logic pb,
		input logic stp, input logic [4:0] md = 5'h0);
		int n;
		@(posedge pclk);
		frame <= sy ? {3'h7, d} : (pen ? {stp, pb, d, 1'b0} : {1'b1, stp, d, 1'b0});
		len <= sy ? 4'h8 : (pen ? 4'hB : 4'hA);
		go <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (busy !== 1'b1 && n < 20);
		go <= 1'b0;
		// Internal clock starts only once the sender holds its frame
		if (md != 5'h0) apb(1'b1, srx_pkg::ADR_MODE0, {27'h0, md});
		while (busy === 1'b1 && n < 2000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 2000) begin
			fail_count++;
			$display("MISMATCH at %0t: frame timeout", $time);
			complete_run();
		end
		repeat (40) @(posedge pclk);
	endtask
	initial begin
		{psel, penable, pwrite, go, take, ssc, sy, idle} = 8'h0;
		sck = 1'b1;
		{paddr, pwdata, frame, len, div} = '0;
		presetn = 1'b0;
		do_reset();
		// ==================================================
		// Reset values and an unmapped place
		apb(1'b0, srx_pkg::ADR_MODE2, 32'h00000040);
		apb(1'b0, srx_pkg::ADR_CTRL, 32'h00000000);
		apb(1'b0, 8'h3C, 32'h00000000, 32'hFFFFFFFF, 1'b1);
		// ==================================================
		// Plain UART frame into the double buffer
		for (int i = 0; i < 4; i++) b[i] = 8'($random(seed));
		apb(1'b1, srx_pkg::ADR_MODE0, 32'h00000002);
		send(b[0], 1'b0, 1'b0, 1'b1);
		chk(32'(irq_n), 32'h1);
		apb(1'b0, srx_pkg::ADR_MODE2, 32'h000000C0);
		apb(1'b0, srx_pkg::ADR_BUF, {24'h0, b[0]});
		apb(1'b0, srx_pkg::ADR_MODE2, 32'h00000040);
		// ==================================================
		// Even parity: a wrong bit, then a bad stop bit
		apb(1'b1, srx_pkg::ADR_MODE0, 32'h0000000A);
		p = ~^b[1];
		send(b[1], 1'b1, p, 1'b1);
		apb(1'b0, srx_pkg::ADR_CTRL, {24'h0, p, 7'h08});
		apb(1'b0, srx_pkg::ADR_CTRL, {24'h0, p, 7'h00});
		apb(1'b0, srx_pkg::ADR_BUF, {24'h0, b[1]});
		send(b[2], 1'b1, ^b[2], 1'b0);
		apb(1'b0, srx_pkg::ADR_CTRL, {24'h0, ^b[2], 7'h04});
		apb(1'b0, srx_pkg::ADR_BUF, {24'h0, b[2]});
		// ==================================================
		// Three unread frames overrun the storage
		do_reset();
		apb(1'b1, srx_pkg::ADR_MODE0, 32'h00000002);
		for (int i = 0; i < 3; i++) send(b[i], 1'b0, 1'b0, 1'b1);
		apb(1'b0, srx_pkg::ADR_CTRL, 32'h00000010, 32'hFFFFFF7F);
		apb(1'b0, srx_pkg::ADR_BUF, {24'h0, b[0]});
		// ==================================================
		// Receive FIFO, four bytes, eight-bit frames only
		do_reset();
		apb(1'b1, srx_pkg::ADR_MODE2, 32'h00000020);
		apb(1'b1, srx_pkg::ADR_MODE1, 32'h00000020);
		apb(1'b1, srx_pkg::ADR_FCNF, 32'h00000001);
		apb(1'b1, srx_pkg::ADR_RFC, 32'h000000C0);
		apb(1'b1, srx_pkg::ADR_MODE0, 32'h00000002);
		for (int i = 0; i < 4; i++) send(b[i], 1'b0, 1'b0, 1'b1);
		chk(32'(irq_n), 32'h1);
		apb(1'b0, srx_pkg::ADR_RFC, 32'h00000010, 32'h0000001C);
		apb(1'b0, srx_pkg::ADR_MODE2, 32'h00000060);
		for (int i = 0; i < 4; i++) apb(1'b0, srx_pkg::ADR_BUF, {24'h0, b[i]});
		apb(1'b0, srx_pkg::ADR_RFC, 32'h00000000, 32'h0000001C);
		// ==================================================
		// Transmit-empty flag: write clears, transmitter take sets
		apb(1'b1, srx_pkg::ADR_BUF, 32'h0000005A);
		apb(1'b0, srx_pkg::ADR_MODE2, 32'h00000020);
		@(posedge pclk);
		take <= 1'b1;
		@(posedge pclk);
		take <= 1'b0;
		apb(1'b0, srx_pkg::ADR_MODE2, 32'h00000060);
		// ==================================================
		// Sync, external clock, rising edge: nothing to send gives underrun
		do_reset();
		sy <= 1'b1;
		idle <= 1'b1;
		apb(1'b1, srx_pkg::ADR_MODE2, 32'h00000020);
		apb(1'b1, srx_pkg::ADR_CTRL, 32'h00000002);
		apb(1'b1, srx_pkg::ADR_MODE0, 32'h00000003);
		fork
			send(b[2], 1'b0, 1'b0, 1'b1);
			repeat (16) begin
				repeat (4) @(posedge pclk);
				sck <= ~sck;
			end
		join
		chk(32'(irq_n), 32'h1);
		apb(1'b0, srx_pkg::ADR_CTRL, 32'h0000000A);
		apb(1'b0, srx_pkg::ADR_BUF, {24'h0, b[2]});
		// ==================================================
		// Sync, internal clock, single buffer: clock parks with a byte held
		do_reset();
		chk({31'h0, sclk_oe_n}, 32'h1);
		send(b[3], 1'b0, 1'b0, 1'b1, 5'h03);
		chk({30'h0, sclk_oe_n, sclk_out}, 32'h1);
		chk(32'(irq_n), 32'h1);
		apb(1'b0, srx_pkg::ADR_MODE2, 32'h000000C0);
		apb(1'b0, srx_pkg::ADR_BUF, {24'h0, b[3]});
		repeat (5) @(posedge pclk);
		complete_run();
	end
endmodule
`default_nettype wire
